// [core/bdc_ctrl.sv]
// Background debug control: enable, activation, secure check, command gating
module bdc_ctrl #(
  parameter int DATA_W = 16
) (
  input  wire logic              CLOCK,
  input  wire logic              RESET_N,
  input  wire logic              CLK_EN,
  input  wire logic [2:0]        MODE_PINS,
  input  wire logic              SECURED,
  input  wire logic              CMD_VALID,
  input  wire logic [3:0]        CMD_CODE,
  input  wire logic [15:0]       CMD_ADDR,
  input  wire logic [DATA_W-1:0] CMD_WDATA,
  output logic                   CMD_READY,
  output logic                   CMD_DONE,
  output logic                   CMD_REJECT,
  output logic      [DATA_W-1:0] CMD_RDATA,
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic      [15:0]       MEM_ADDR,
  output logic      [DATA_W-1:0] MEM_WDATA,
  input  wire logic              MEM_ACK,
  input  wire logic [DATA_W-1:0] MEM_RDATA,
  input  wire logic              EXT_TAG,
  input  wire logic              CPU_HALT_INSTR,
  input  wire logic              BRK_REQ,
  input  wire logic              INSTR_DONE,
  input  wire logic              ERASE_CHK_DONE,
  input  wire logic              EEPROM_ERASED,
  input  wire logic              FLASH_ERASED,
  output logic                   ERASE_CHK_START,
  output logic                   DEBUG_ENABLE,
  output logic                   DEBUG_ACTIVE,
  output logic                   UNSECURE,
  output logic                   SECURE_TABLE_ON,
  output logic                   FW_LOOP,
  output logic                   RUN_DEBUG_FW,
  output logic      [7:0]        EEPROM_POS,
  output logic      [7:0]        PROG_PAGE,
  output logic      [7:0]        STATUS
);
  initial begin
    if (DATA_W < 8 || DATA_W > 16) $error("DATA_W must be 8 to 16");
  end

  // ***************************************************************
  // Pin synchronisers and mode sampling
  // ***************************************************************
  logic [4:0] pins_s;
  bdc_sync #(.WIDTH(5)) u_sync (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .ce    (CLK_EN),
    .din   ({MODE_PINS, SECURED, EXT_TAG}),
    .dout  (pins_s)
  );
  logic [1:0] boot_cnt_q;
  logic       ssc_q;
  logic       sec_q;
  logic       booted;
  assign booted = boot_cnt_q == 2'h3;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      boot_cnt_q <= 2'h0;
    end else if (CLK_EN && !booted) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end
  // Capture straps once synchroniser has settled
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ssc_q <= 1'b0;
      sec_q <= 1'b0;
    end else if (CLK_EN && boot_cnt_q == 2'h2) begin
      ssc_q <= pins_s[4:2] == bdc_pkg::BDC_MODE_SSC;
      sec_q <= pins_s[1];
    end
  end
  logic tag_s;
  assign tag_s = pins_s[0];

  // ***************************************************************
  // Secure check sequence
  // ***************************************************************
  typedef enum logic [2:0] {
    BDC_S_BOOT, BDC_S_CHECK, BDC_S_UNSECURE_FLAG, BDC_S_LOOP, BDC_S_RUN
  } bdc_sec_e;
  bdc_sec_e sec_st_q;
  logic     secure_load;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      sec_st_q <= BDC_S_BOOT;
    end else if (CLK_EN) begin
      unique case (sec_st_q)
        BDC_S_BOOT: begin
          if (booted) begin
            sec_st_q <= (ssc_q && sec_q) ? BDC_S_CHECK : BDC_S_RUN;
          end
        end
        BDC_S_CHECK: begin
          if (ERASE_CHK_DONE) begin
            sec_st_q <= (EEPROM_ERASED && FLASH_ERASED) ? BDC_S_UNSECURE_FLAG : BDC_S_LOOP;
          end
        end
        BDC_S_UNSECURE_FLAG: sec_st_q <= BDC_S_RUN;
        BDC_S_LOOP:  sec_st_q <= BDC_S_LOOP;
        BDC_S_RUN:   sec_st_q <= BDC_S_RUN;
      endcase
    end
  end
  assign ERASE_CHK_START = sec_st_q == BDC_S_CHECK;
  assign SECURE_TABLE_ON = sec_st_q == BDC_S_CHECK || sec_st_q == BDC_S_LOOP;
  assign FW_LOOP         = sec_st_q == BDC_S_LOOP;
  assign secure_load     = sec_st_q == BDC_S_CHECK && ERASE_CHK_DONE;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      EEPROM_POS <= 8'h00;
      PROG_PAGE  <= 8'h00;
    end else if (CLK_EN && secure_load) begin
      EEPROM_POS <= bdc_pkg::BDC_EEPOS_SECURED;
      PROG_PAGE  <= bdc_pkg::BDC_PAGE_SECURED;
    end
  end

  // ***************************************************************
  // Command decode
  // ***************************************************************
  bdc_pkg::bdc_cmd_e cmd;
  assign cmd = bdc_pkg::bdc_cmd_e'(CMD_CODE);
  logic is_hw;
  logic is_fw;
  logic sts_hit;
  logic busy_q;
  assign is_hw = cmd inside {bdc_pkg::BDC_CMD_BACKGROUND, bdc_pkg::BDC_CMD_READ_BYTE,
                  bdc_pkg::BDC_CMD_WRITE_BYTE, bdc_pkg::BDC_CMD_READ_MEM,
                  bdc_pkg::BDC_CMD_WRITE_MEM};
  assign is_fw = cmd inside {bdc_pkg::BDC_CMD_READ_REG, bdc_pkg::BDC_CMD_WRITE_REG,
                  bdc_pkg::BDC_CMD_GO};
  assign sts_hit = CMD_ADDR == bdc_pkg::BDC_STS_ADDR;
  // Hardware commands wait only for boot and a free memory path
  assign CMD_READY = booted && !busy_q;
  logic take;
  logic fw_ok;
  assign take  = CLK_EN && CMD_VALID && CMD_READY;
  assign fw_ok = DEBUG_ACTIVE && sec_st_q == BDC_S_RUN;
  logic hw_wr_sts;
  assign hw_wr_sts = take && cmd == bdc_pkg::BDC_CMD_WRITE_BYTE && sts_hit;

  // ***************************************************************
  // Enable, active and unsecure flags
  // ***************************************************************
  logic pend_q;
  logic trig;
  assign trig = (take && cmd == bdc_pkg::BDC_CMD_BACKGROUND) || tag_s || CPU_HALT_INSTR
                || BRK_REQ;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      DEBUG_ENABLE <= 1'b0;
    end else if (CLK_EN) begin
      if (booted && ssc_q && !sec_q && sec_st_q == BDC_S_BOOT) begin
        DEBUG_ENABLE <= 1'b1;
      end else if (secure_load) begin
        DEBUG_ENABLE <= 1'b1;
      end else if (hw_wr_sts) begin
        DEBUG_ENABLE <= CMD_WDATA[bdc_pkg::BDC_STS_ENABLE_BIT];
      end
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      UNSECURE <= 1'b0;
    end else if (CLK_EN && sec_st_q == BDC_S_UNSECURE_FLAG) begin
      UNSECURE <= 1'b1;
    end
  end
  // Pending activation waits for the current instruction to end
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      pend_q <= 1'b0;
    end else if (CLK_EN) begin
      if (pend_q && INSTR_DONE) begin
        pend_q <= 1'b0;
      end else if (DEBUG_ENABLE && !DEBUG_ACTIVE && trig) begin
        pend_q <= 1'b1;
      end
    end
  end
  logic go_exit;
  assign go_exit = take && cmd == bdc_pkg::BDC_CMD_GO && fw_ok;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      DEBUG_ACTIVE <= 1'b0;
    end else if (CLK_EN) begin
      if (booted && ssc_q && !sec_q && sec_st_q == BDC_S_BOOT) begin
        DEBUG_ACTIVE <= 1'b1;
      end else if (sec_st_q == BDC_S_UNSECURE_FLAG) begin
        DEBUG_ACTIVE <= 1'b1;
      end else if (pend_q && INSTR_DONE) begin
        DEBUG_ACTIVE <= 1'b1;
      end else if (go_exit) begin
        DEBUG_ACTIVE <= 1'b0;
      end
    end
  end
  assign RUN_DEBUG_FW = DEBUG_ACTIVE && !SECURE_TABLE_ON;
  always_comb begin
    STATUS = 8'h00;
    STATUS[bdc_pkg::BDC_STS_ENABLE_BIT] = DEBUG_ENABLE;
    STATUS[bdc_pkg::BDC_STS_ACTIVE_BIT] = DEBUG_ACTIVE;
    STATUS[bdc_pkg::BDC_STS_UNSECURE_FLAG_BIT]  = UNSECURE;
  end

  // ***************************************************************
  // Memory path for hardware commands
  // ***************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      busy_q    <= 1'b0;
      MEM_REQ   <= 1'b0;
      MEM_WE    <= 1'b0;
      MEM_ADDR  <= 16'h0000;
      MEM_WDATA <= '0;
    end else if (CLK_EN) begin
      if (busy_q && MEM_ACK) begin
        busy_q  <= 1'b0;
        MEM_REQ <= 1'b0;
      end else if (take && !sts_hit && cmd inside {bdc_pkg::BDC_CMD_READ_BYTE,
                   bdc_pkg::BDC_CMD_WRITE_BYTE, bdc_pkg::BDC_CMD_READ_MEM,
                   bdc_pkg::BDC_CMD_WRITE_MEM}) begin
        busy_q    <= 1'b1;
        MEM_REQ   <= 1'b1;
        MEM_WE    <= cmd inside {bdc_pkg::BDC_CMD_WRITE_BYTE, bdc_pkg::BDC_CMD_WRITE_MEM};
        MEM_ADDR  <= CMD_ADDR;
        MEM_WDATA <= CMD_WDATA;
      end
    end
  end

  // ***************************************************************
  // CPU register access and answers
  // ***************************************************************
  logic [DATA_W-1:0] reg_rdata;
  logic              reg_wr;
  assign reg_wr = take && cmd == bdc_pkg::BDC_CMD_WRITE_REG && fw_ok;
  bdc_regfile #(.NREG(5), .WIDTH(DATA_W)) u_regs (
    .clk         (CLOCK),
    .rst_n       (RESET_N),
    .ce          (CLK_EN),
    .wr          (reg_wr),
    .secure_load (secure_load),
    .idx         (CMD_ADDR[2:0]),
    .wdata       (CMD_WDATA),
    .rdata       (reg_rdata)
  );
  logic reg_rd_q;
  logic sts_rd_q;
  logic imm_q;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      reg_rd_q   <= 1'b0;
      sts_rd_q   <= 1'b0;
      imm_q      <= 1'b0;
      CMD_REJECT <= 1'b0;
    end else if (CLK_EN) begin
      reg_rd_q   <= take && cmd == bdc_pkg::BDC_CMD_READ_REG && fw_ok;
      sts_rd_q   <= take && cmd == bdc_pkg::BDC_CMD_READ_BYTE && sts_hit;
      imm_q      <= take && (cmd == bdc_pkg::BDC_CMD_BACKGROUND || hw_wr_sts
                    || (is_fw && fw_ok && cmd != bdc_pkg::BDC_CMD_READ_REG));
      CMD_REJECT <= take && ((is_fw && !fw_ok) || (!is_fw && !is_hw));
    end
  end
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      CMD_DONE  <= 1'b0;
      CMD_RDATA <= '0;
    end else if (CLK_EN) begin
      CMD_DONE <= reg_rd_q || sts_rd_q || imm_q || (busy_q && MEM_ACK);
      if (busy_q && MEM_ACK) begin
        CMD_RDATA <= MEM_RDATA;
      end else if (reg_rd_q) begin
        CMD_RDATA <= reg_rdata;
      end else if (sts_rd_q) begin
        CMD_RDATA <= DATA_W'(STATUS);
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_fw_blocked;
    @(posedge CLOCK) disable iff (!RESET_N)
      (take && is_fw && !fw_ok) |-> ##2 !CMD_DONE;
  endproperty
  a_fw_blocked: assert property (p_fw_blocked) else $error("fw cmd while inactive");
  property p_reject;
    @(posedge CLOCK) disable iff (!RESET_N)
      (take && is_fw && !fw_ok) |=> CMD_REJECT;
  endproperty
  a_reject: assert property (p_reject) else $error("fw cmd not refused");
  property p_act_needs_en;
    @(posedge CLOCK) disable iff (!RESET_N)
      $rose(DEBUG_ACTIVE) |-> DEBUG_ENABLE || $past(sec_st_q) == BDC_S_BOOT;
  endproperty
  a_act_needs_en: assert property (p_act_needs_en) else $error("active without enable");
  property p_unsecure_flag;
    @(posedge CLOCK) disable iff (!RESET_N)
      (CLK_EN && sec_st_q == BDC_S_UNSECURE_FLAG) |=> UNSECURE && DEBUG_ACTIVE;
  endproperty
  a_unsecure_flag: assert property (p_unsecure_flag) else $error("unsecure not set");
  property p_loop;
    @(posedge CLOCK) disable iff (!RESET_N)
      FW_LOOP |-> DEBUG_ENABLE && !UNSECURE;
  endproperty
  a_loop: assert property (p_loop) else $error("loop flags wrong");
  property p_regs_moved;
    @(posedge CLOCK) disable iff (!RESET_N)
      (CLK_EN && secure_load) |=> PROG_PAGE == bdc_pkg::BDC_PAGE_SECURED;
  endproperty
  a_regs_moved: assert property (p_regs_moved) else $error("page not moved");
  property p_finish_instr;
    @(posedge CLOCK) disable iff (!RESET_N)
      (CLK_EN && pend_q && INSTR_DONE) |=> DEBUG_ACTIVE;
  endproperty
  a_finish_instr: assert property (p_finish_instr) else $error("activation late");
  property p_enable_wr;
    @(posedge CLOCK) disable iff (!RESET_N)
      (hw_wr_sts && !secure_load && sec_st_q != BDC_S_BOOT) |=>
        DEBUG_ENABLE == $past(CMD_WDATA[bdc_pkg::BDC_STS_ENABLE_BIT]);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable write lost");
  property p_status;
    @(posedge CLOCK) disable iff (!RESET_N)
      STATUS[bdc_pkg::BDC_STS_UNSECURE_FLAG_BIT] == UNSECURE;
  endproperty
  a_status: assert property (p_status) else $error("status mismatch");
endmodule : bdc_ctrl

// [core/bdc_pkg.sv]
// Package of constants for the background debug control block
// What this block does
// - Hardware commands read and write any CPU-reachable memory, and enter debug mode.
// - Firmware commands access accumulator, index registers, stack, PC, and exit debug.
// - Hardware commands run at any time in any mode, with few exceptions.
// - Firmware commands run only while debug mode is active.
// - Secured special single-chip reset maps secure table and checks memories erased.
// - Both erased: set unsecure flag, jump to standard table, allow all commands.
// - Not erased: set enable flag only, firmware loops, firmware commands stay blocked.
// - After the secure check, CPU registers and page registers leave reset values.
// - Debug mode activates only once enabled through the status register enable flag.
// - Enabled debug activates on host command, tagging, halt instruction, or breakpoint.
// - On activation CPU finishes its instruction, then runs standard debug firmware.
// - Out of unsecured special single-chip reset, debug is already enabled and active.
// - Special single-chip mode means all three mode inputs low at reset.
package bdc_pkg;
  // ***************************************************************
  // Commands
  // ***************************************************************
  typedef enum logic [3:0] {
    BDC_CMD_NONE, BDC_CMD_BACKGROUND, BDC_CMD_READ_BYTE, BDC_CMD_WRITE_BYTE,
    BDC_CMD_READ_MEM, BDC_CMD_WRITE_MEM, BDC_CMD_READ_REG, BDC_CMD_WRITE_REG,
    BDC_CMD_GO
  } bdc_cmd_e;
  typedef enum logic [2:0] {
    BDC_REG_ACC, BDC_REG_IX, BDC_REG_IY, BDC_REG_SP, BDC_REG_PC
  } bdc_reg_e;
  // ***************************************************************
  // Status register layout
  // ***************************************************************
  localparam int        BDC_STS_ENABLE_BIT = 7;
  localparam int        BDC_STS_ACTIVE_BIT = 6;
  localparam int        BDC_STS_UNSECURE_FLAG_BIT  = 2;
  localparam logic [15:0] BDC_STS_ADDR     = 16'hFF01;
  localparam logic [7:0]  BDC_ERASED_BYTE  = 8'hFF;
  localparam logic [15:0] BDC_REG_RESET    = 16'h0000;
  localparam logic [15:0] BDC_REG_SECURED  = 16'hFFFF;
  localparam logic [7:0]  BDC_PAGE_SECURED = 8'h3F;
  localparam logic [7:0]  BDC_EEPOS_SECURED = 8'h11;
  localparam logic [2:0]  BDC_MODE_SSC     = 3'h0;
endpackage : bdc_pkg

// [core/bdc_regfile.sv]
// CPU register shadow bank for firmware-command access
module bdc_regfile #(
  parameter int NREG  = 5,
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             wr,
  input  wire logic             secure_load,
  input  wire logic [2:0]       idx,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata
);
  initial begin
    if (NREG < 1 || NREG > 8) $error("NREG out of range");
  end
  logic [WIDTH-1:0] mem_q [NREG];
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mem_q[g] <= WIDTH'(bdc_pkg::BDC_REG_RESET);
        end else if (ce) begin
          if (secure_load) begin
            mem_q[g] <= WIDTH'(bdc_pkg::BDC_REG_SECURED);
          end else if (wr && idx == 3'(g)) begin
            mem_q[g] <= wdata;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= (int'(idx) < NREG) ? mem_q[idx] : '0;
    end
  end
endmodule : bdc_regfile

// [core/bdc_sync.sv]
// Two flip-flop synchroniser for pin inputs
module bdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else if (ce) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : bdc_sync

// [dv/bdc_host.sv]
// Debug host model: issues one command at a time and collects the answer
module bdc_host (
  input  wire logic        clock,
  input  wire logic        cmd_ready,
  input  wire logic        cmd_done,
  input  wire logic        cmd_reject,
  input  wire logic [15:0] cmd_rdata,
  output logic             cmd_valid,
  output logic [3:0]       cmd_code,
  output logic [15:0]      cmd_addr,
  output logic [15:0]      cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 4'h0;
    cmd_addr  = 16'h0000;
    cmd_wdata = 16'h0000;
  end
  // Request held until the taking edge, lines scrambled once released
  task automatic issue(input logic [3:0] code, input logic [15:0] addr, input logic [15:0] wdata,
                       output logic rej, output logic [15:0] rd, output logic lost);
    int i;
    lost = 1'b1;
    rej  = 1'b0;
    rd   = 16'h0000;
    @(negedge clock);
    for (i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_addr  = addr;
    cmd_wdata = wdata;
    @(posedge clock);
    for (i = 0; i < 40; i++) begin
      @(negedge clock);
      cmd_valid = 1'b0;
      cmd_addr  = ~addr;
      cmd_wdata = ~wdata;
      if (cmd_done === 1'b1 || cmd_reject === 1'b1) begin
        rej  = cmd_reject;
        rd   = cmd_rdata;
        lost = 1'b0;
        break;
      end
    end
  endtask : issue
  // Enable through a byte write to the status location
  task automatic enable(input logic en);
    logic        r;
    logic        l;
    logic [15:0] d;
    d = 16'h0000;
    d[bdc_pkg::BDC_STS_ENABLE_BIT] = en;
    issue(bdc_pkg::BDC_CMD_WRITE_BYTE, bdc_pkg::BDC_STS_ADDR, d, r, d, l);
  endtask : enable
endmodule : bdc_host

// [dv/tb_top.sv]
// Testbench for the background debug control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, secured, cmd_valid, cmd_ready, cmd_done, cmd_reject;
  logic [2:0]  mode_pins;
  logic [3:0]  cmd_code;
  logic [15:0] cmd_addr, cmd_wdata, cmd_rdata, mem_addr, mem_wdata;
  logic        mem_req, mem_we, erase_chk_start, debug_enable, debug_active, unsecure;
  logic        secure_table_on, fw_loop, run_debug_fw;
  logic [7:0]  eeprom_pos, prog_page, status;
  logic        mem_ack = 1'b0;
  logic        clk_en = 1'b1;
  logic [15:0] mem_rdata = 16'h0000;
  logic        ext_tag = 1'b0, cpu_halt = 1'b0, brk_req = 1'b0, instr_done = 1'b0;
  logic        chk_done = 1'b0, ee_erased = 1'b0, fl_erased = 1'b0;
  logic [15:0] mem_q [256];
  logic [15:0] rd;
  logic        rej;
  int          mem_wait = 0, mem_n = 0, cyc = 0, seed = 71, bad_count = 0, checks_done = 0;
  int          m, k, j;
  bdc_ctrl uut (.CLOCK(clock), .RESET_N(reset_n), .CLK_EN(clk_en), .MODE_PINS(mode_pins),
    .SECURED(secured), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_ADDR(cmd_addr),
    .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done),
    .CMD_REJECT(cmd_reject), .CMD_RDATA(cmd_rdata), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
    .EXT_TAG(ext_tag), .CPU_HALT_INSTR(cpu_halt), .BRK_REQ(brk_req),
    .INSTR_DONE(instr_done), .ERASE_CHK_DONE(chk_done), .EEPROM_ERASED(ee_erased),
    .FLASH_ERASED(fl_erased), .ERASE_CHK_START(erase_chk_start),
    .DEBUG_ENABLE(debug_enable), .DEBUG_ACTIVE(debug_active), .UNSECURE(unsecure),
    .SECURE_TABLE_ON(secure_table_on), .FW_LOOP(fw_loop), .RUN_DEBUG_FW(run_debug_fw),
    .EEPROM_POS(eeprom_pos), .PROG_PAGE(prog_page), .STATUS(status));
  bdc_host host (.clock(clock), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .cmd_reject(cmd_reject), .cmd_rdata(cmd_rdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  // ***************************************************************
  // Clock, target memory, watchdog
  // ***************************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Memory answers after 0 to 3 cycles, data scrambled outside the ack
  always @(negedge clock) begin
    if (mem_req === 1'b1 && mem_ack === 1'b0 && mem_wait == 0) begin
      mem_ack = 1'b1;
      mem_rdata = mem_q[mem_addr[7:0]];
      if (mem_we === 1'b1) mem_q[mem_addr[7:0]] = mem_wdata;
      mem_n++;
      mem_wait = mem_n % 4;
    end else begin
      if (mem_req === 1'b1 && mem_ack === 1'b0) mem_wait--;
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ***************************************************************
  // Checking and stimulus tasks
  // ***************************************************************
  task automatic tally_and_finish();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] stat_exp(input logic en, input logic act, input logic uns);
    logic [7:0] s;
    s = 8'h00;
    s[bdc_pkg::BDC_STS_ENABLE_BIT] = en;
    s[bdc_pkg::BDC_STS_ACTIVE_BIT] = act;
    s[bdc_pkg::BDC_STS_UNSECURE_FLAG_BIT]  = uns;
    return s;
  endfunction : stat_exp
  task automatic cmd(input logic [3:0] c, input logic [15:0] a, input logic [15:0] d);
    logic lost;
    host.issue(c, a, d, rej, rd, lost);
    chk(lost, 1'b0);
  endtask : cmd
  task automatic rst(input logic [2:0] md, input logic s);
    int i;
    @(negedge clock);
    reset_n = 1'b0;
    mode_pins = md;
    secured = s;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    for (i = 0; i < 20 && (s ? erase_chk_start : cmd_ready) !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
  endtask : rst
  task automatic mem_rw(input int n);
    int          i;
    logic [15:0] a, d;
    for (i = 0; i < n; i++) begin
      a = {8'h20, 8'($random(seed))};
      d = 16'($random(seed));
      cmd(bdc_pkg::BDC_CMD_WRITE_MEM, a, d);
      chk(rej, 1'b0);
      cmd(bdc_pkg::BDC_CMD_READ_MEM, a, 16'h0000);
      chk(rd, d);
    end
  endtask : mem_rw
  task automatic reg_rw();
    int          r;
    logic [15:0] d;
    for (r = 0; r < 5; r++) begin
      d = 16'($random(seed));
      cmd(bdc_pkg::BDC_CMD_WRITE_REG, 16'(r), d);
      cmd(bdc_pkg::BDC_CMD_READ_REG, 16'(r), 16'h0000);
      chk(rd, d);
    end
  endtask : reg_rw
  // Trigger k: 0 command, 1 tag, 2 halt instruction, 3 breakpoint
  task automatic trig(input int t, input logic en);
    if (t == 0) cmd(bdc_pkg::BDC_CMD_BACKGROUND, 16'h0000, 16'h0000);
    else begin
      ext_tag = (t == 1);
      cpu_halt = (t == 2);
      brk_req = (t == 3);
      repeat (2) @(negedge clock);
      ext_tag = 1'b0;
      cpu_halt = 1'b0;
      brk_req = 1'b0;
    end
    repeat (4) @(negedge clock);
    chk(debug_active, 1'b0);
    instr_done = 1'b1;
    @(negedge clock);
    instr_done = 1'b0;
    repeat (2) @(negedge clock);
    chk(debug_active, en);
    chk(run_debug_fw, en);
  endtask : trig
  task automatic erase_done(input logic ee, input logic fl);
    chk(erase_chk_start, 1'b1);
    chk(secure_table_on, 1'b1);
    chk_done = 1'b1;
    ee_erased = ee;
    fl_erased = fl;
    @(negedge clock);
    chk_done = 1'b0;
    ee_erased = ~ee;
    fl_erased = ~fl;
    repeat (3) @(negedge clock);
    chk(eeprom_pos, bdc_pkg::BDC_EEPOS_SECURED);
    chk(prog_page, bdc_pkg::BDC_PAGE_SECURED);
  endtask : erase_done
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    reset_n = 1'b0;
    mode_pins = 3'h1;
    secured = 1'b0;
    for (m = 1; m < 8; m++) begin
      rst(m[2:0], 1'b0);
      chk(debug_enable, 1'b0);
      chk(debug_active, 1'b0);
    end
    for (k = 0; k < 4; k++) trig(k, 1'b0);
    cmd(bdc_pkg::BDC_CMD_READ_REG, 16'h0000, 16'h0000);
    chk(rej, 1'b1);
    cmd(4'hF, 16'h0000, 16'h0000);
    chk(rej, 1'b1);
    mem_rw(6);
    host.enable(1'b1);
    chk(debug_enable, 1'b1);
    cmd(bdc_pkg::BDC_CMD_READ_BYTE, bdc_pkg::BDC_STS_ADDR, 16'h0000);
    chk(rd[7:0], stat_exp(1'b1, 1'b0, 1'b0));
    clk_en = 1'b0;
    cpu_halt = 1'b1;
    instr_done = 1'b1;
    repeat (3) @(negedge clock);
    cpu_halt = 1'b0;
    instr_done = 1'b0;
    clk_en = 1'b1;
    chk(debug_active, 1'b0);
    for (k = 0; k < 4; k++) begin
      trig(k, 1'b1);
      if (k == 0) begin
        reg_rw();
        chk(status, stat_exp(1'b1, 1'b1, 1'b0));
        mem_rw(4);
      end
      cmd(bdc_pkg::BDC_CMD_GO, 16'h0000, 16'h0000);
      repeat (2) @(negedge clock);
      chk(debug_active, 1'b0);
    end
    rst(3'h0, 1'b0);
    chk(debug_enable, 1'b1);
    chk(debug_active, 1'b1);
    rst(3'h0, 1'b1);
    erase_done(1'b1, 1'b1);
    chk(unsecure, 1'b1);
    chk(secure_table_on, 1'b0);
    cmd(bdc_pkg::BDC_CMD_READ_REG, 16'h0000, 16'h0000);
    chk(rej, 1'b0);
    chk(rd, bdc_pkg::BDC_REG_SECURED);
    for (j = 0; j < 3; j++) begin
      rst(3'h0, 1'b1);
      erase_done(j[0], j[1]);
      chk({debug_enable, unsecure, fw_loop}, 3'h5);
      cmd(bdc_pkg::BDC_CMD_READ_REG, 16'h0001, 16'h0000);
      chk(rej, 1'b1);
      mem_rw(2);
    end
    tally_and_finish();
  end
endmodule : tb_top
